// ===== aseq_top.sv
/*
  Sampling sequencer for a 12-bit pipelined converter with 16 inputs,
  with an AXI4-Lite register slave and one level interrupt.
  Assumes an analog front end that presents the quantised value of the
  selected channels on conv_in_a/conv_in_b, and synchronous triggers.
*/
`timescale 1ns/1ps
module aseq_top
  import aseq_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [1:0] event_manager_triggers,
  input wire logic external_conversion_start,
  input wire logic [11:0] conv_in_a,
  input wire logic [11:0] conv_in_b,
  output logic sample_hold,
  output logic sample_strobe,
  output logic [3:0] mux_a_sel,
  output logic [3:0] mux_b_sel,
  output logic irq
);
  // ==========================================================
  // Declarations
  logic awready_q, aw_full_q, wready_q, w_full_q, bvalid_q, arready_q, rvalid_q;
  logic [AW-1:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] ctrl1_q, ctrl3_q;
  logic [1:0] mask_q, sts_q, sts_clr;
  logic sw_go_q, irq_q;
  logic [1:0] ev_prev_q;
  logic ext_prev_q;
  aseq_state_t st_q;
  logic [4:0] hcnt_q, hold_last, gap_last;
  logic [3:0] div_cnt_q, acq_q, mux_a_q, mux_b_q;
  logic hph_q, sh_q, strobe_q, sim_q;
  logic pv_q [PIPE_N];
  logic pm_q [PIPE_N];
  logic [11:0] pa_q [PIPE_N];
  logic [11:0] pb_q [PIPE_N];
  logic [11:0] res_a_q, res_b_q;
  logic [IRQ_LAG-1:0] lag_a_q, lag_b_q;
  logic wr_do, core_on, trig, accept, half_tick, conv_edge, cap, upd_a, upd_b, busy;

  // ==========================================================
  // Decoding helpers
  function automatic logic is_mapped(input logic [AW-1:0] a);
    return a inside {OFF_CTRL1, OFF_CTRL3, OFF_SWTRIG, OFF_STATUS, OFF_MASK,
                     OFF_RES_A, OFF_RES_B};
  endfunction : is_mapped

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic [31:0] rd_word(input logic [AW-1:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      OFF_CTRL1: r = ctrl1_q;
      OFF_CTRL3: r = ctrl3_q;
      OFF_STATUS: begin
        r[ST_B_BIT:ST_A_BIT] = sts_q;
        r[ST_BUSY_BIT] = busy;
      end
      OFF_MASK: r[1:0] = mask_q;
      OFF_RES_A: r[11:0] = res_a_q;
      OFF_RES_B: r[11:0] = res_b_q;
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction : rd_word

  // ==========================================================
  // AXI4-Lite slave; address and data may arrive in either order
  assign wr_do = aw_full_q && w_full_q && !bvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      aw_full_q <= 1'b0;
      awaddr_q <= '0;
      wready_q <= 1'b0;
      w_full_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OK;
    end else begin
      if (awvalid && awready_q) begin
        aw_full_q <= 1'b1;
        awaddr_q <= awaddr;
        awready_q <= 1'b0;
      end else if (wr_do) begin
        aw_full_q <= 1'b0;
      end else if (!aw_full_q) begin
        awready_q <= 1'b1;
      end
      if (wvalid && wready_q) begin
        w_full_q <= 1'b1;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
        wready_q <= 1'b0;
      end else if (wr_do) begin
        w_full_q <= 1'b0;
      end else if (!w_full_q) begin
        wready_q <= 1'b1;
      end
      if (wr_do) begin
        bvalid_q <= 1'b1;
        bresp_q <= is_mapped(awaddr_q) ? RESP_OK : RESP_ERR;
      end else if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OK;
    end else if (arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_word(araddr);
      rresp_q <= is_mapped(araddr) ? RESP_OK : RESP_ERR;
    end else if (rvalid_q && rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end else if (!rvalid_q) begin
      arready_q <= 1'b1;
    end
  end

  // ==========================================================
  // Control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl1_q <= C1_RST;
      ctrl3_q <= C3_RST;
      mask_q <= MASK_RST;
      sw_go_q <= 1'b0;
    end else begin
      sw_go_q <= wr_do && awaddr_q == OFF_SWTRIG && wstrb_q[0] && wdata_q[SW_GO_BIT];
      if (wr_do && awaddr_q == OFF_CTRL1) begin
        ctrl1_q <= merge(ctrl1_q, wdata_q, wstrb_q) & C1_WMASK;
      end
      // Power bits are independent flops; clearing them all at once is legal
      if (wr_do && awaddr_q == OFF_CTRL3) begin
        ctrl3_q <= merge(ctrl3_q, wdata_q, wstrb_q) & C3_WMASK;
      end
      if (wr_do && awaddr_q == OFF_MASK && wstrb_q[0]) begin
        mask_q <= wdata_q[1:0];
      end
    end
  end

  // ==========================================================
  // Trigger sources; the core must be powered for a trigger to count
  assign core_on = ctrl3_q[C3_CORE_BIT];
  assign trig = sw_go_q
    || (ctrl1_q[C1_EV_EN_BIT] && |(event_manager_triggers & ~ev_prev_q))
    || (ctrl1_q[C1_EXT_EN_BIT] && external_conversion_start && !ext_prev_q);
  assign accept = core_on && trig;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ev_prev_q <= 2'h0;
      ext_prev_q <= 1'b0;
    end else begin
      ev_prev_q <= event_manager_triggers;
      ext_prev_q <= external_conversion_start;
    end
  end

  // ==========================================================
  // Sequencer, stepped in half converter clocks
  // Converter clock period is 2*(div+1) system clocks, never above half rate
  assign half_tick = div_cnt_q == ctrl3_q[C3_DIV_LSB +: 4];
  assign conv_edge = half_tick && !hph_q && core_on && !accept;
  assign hold_last = {acq_q, 1'b1};
  assign gap_last = sim_q ? 5'(2 * SIM_GAP_CLKS - 1) : 5'(2 * SEQ_GAP_CLKS - 1);
  assign cap = half_tick && core_on && !accept && st_q == ST_HOLD && hcnt_q == hold_last;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= ST_IDLE;
      hcnt_q <= 5'h00;
      div_cnt_q <= 4'h0;
      hph_q <= 1'b0;
      sh_q <= 1'b0;
      strobe_q <= 1'b0;
      acq_q <= 4'h0;
      sim_q <= 1'b0;
      mux_a_q <= 4'h0;
      mux_b_q <= 4'h0;
    end else begin
      strobe_q <= 1'b0;
      if (!core_on) begin
        st_q <= ST_IDLE;
        sh_q <= 1'b0;
      end else if (accept) begin
        // Restart all timing so the delay to sampling is exact
        st_q <= ST_DELAY;
        hcnt_q <= 5'h00;
        div_cnt_q <= 4'h0;
        hph_q <= 1'b0;
        sh_q <= 1'b0;
        acq_q <= ctrl1_q[C1_ACQ_LSB +: 4];
        sim_q <= ctrl1_q[C1_MODE_BIT];
        if (ctrl1_q[C1_MODE_BIT]) begin
          mux_a_q <= {1'b0, ctrl1_q[C1_CHAN_LSB +: 3]};
          mux_b_q <= {1'b1, ctrl1_q[C1_CHAN_LSB +: 3]};
        end else begin
          mux_a_q <= ctrl1_q[C1_CHAN_LSB +: 4];
          mux_b_q <= ctrl1_q[C1_CHAN_LSB +: 4];
        end
      end else begin
        div_cnt_q <= half_tick ? 4'h0 : div_cnt_q + 4'h1;
        if (half_tick) begin
          hph_q <= ~hph_q;
          hcnt_q <= hcnt_q + 5'h01;
          case (st_q)
            ST_IDLE: hcnt_q <= 5'h00;
            ST_DELAY: begin
              if (hcnt_q == 5'(DELAY_HALVES - 1)) begin
                st_q <= ST_HOLD;
                hcnt_q <= 5'h00;
                sh_q <= 1'b1;
              end
            end
            ST_HOLD: begin
              if (hcnt_q == hold_last) begin
                st_q <= ST_GAP;
                hcnt_q <= 5'h00;
                sh_q <= 1'b0;
                strobe_q <= 1'b1;
              end
            end
            ST_GAP: begin
              if (hcnt_q == gap_last) begin
                hcnt_q <= 5'h00;
                if (ctrl1_q[C1_CONT_BIT]) begin
                  st_q <= ST_HOLD;
                  sh_q <= 1'b1;
                end else begin
                  st_q <= ST_IDLE;
                end
              end
            end
            default: st_q <= ST_IDLE;
          endcase
        end
      end
    end
  end

  // ==========================================================
  // Conversion pipeline: sample enters stage 0, A leaves stage 3, B stage 4
  for (genvar g = 0; g < PIPE_N; g++) begin : g_pipe
    // Clamped so stage 0 never names an index below the array
    localparam int PREV = (g > 0) ? g - 1 : 0;
    always_ff @(posedge aclk) begin
      if (!aresetn || accept || !core_on) begin
        pv_q[g] <= 1'b0;
        pm_q[g] <= 1'b0;
        pa_q[g] <= 12'h000;
        pb_q[g] <= 12'h000;
      end else if (conv_edge) begin
        if (g == 0) begin
          pv_q[g] <= cap;
          pm_q[g] <= sim_q;
          pa_q[g] <= conv_in_a;
          pb_q[g] <= conv_in_b;
        end else begin
          pv_q[g] <= pv_q[PREV];
          pm_q[g] <= pm_q[PREV];
          pa_q[g] <= pa_q[PREV];
          pb_q[g] <= pb_q[PREV];
        end
      end
    end
  end

  assign upd_a = conv_edge && pv_q[RES_A_LAT-1];
  assign upd_b = conv_edge && pv_q[RES_B_LAT-1] && pm_q[RES_B_LAT-1];
  assign busy = st_q != ST_IDLE || pv_q[0] || pv_q[1] || pv_q[2] || pv_q[3] || pv_q[4];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      res_a_q <= 12'h000;
      res_b_q <= 12'h000;
    end else begin
      if (upd_a) begin
        res_a_q <= pa_q[RES_A_LAT-1];
      end
      if (upd_b) begin
        res_b_q <= pb_q[RES_B_LAT-1];
      end
    end
  end

  // ==========================================================
  // Interrupts; flags lag the result so software never reads a stale word
  assign sts_clr = (wr_do && awaddr_q == OFF_STATUS && wstrb_q[0]) ? wdata_q[1:0] : 2'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lag_a_q <= '0;
      lag_b_q <= '0;
      sts_q <= 2'h0;
      irq_q <= 1'b0;
    end else begin
      lag_a_q <= {lag_a_q[IRQ_LAG-2:0], upd_a};
      lag_b_q <= {lag_b_q[IRQ_LAG-2:0], upd_b};
      // Set beats clear so a flag raised during the clear write survives
      sts_q <= (sts_q & ~sts_clr) | {lag_b_q[IRQ_LAG-1], lag_a_q[IRQ_LAG-1]};
      irq_q <= |(sts_q & mask_q);
    end
  end

  // ==========================================================
  // Outputs
  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign sample_hold = sh_q;
  assign sample_strobe = strobe_q;
  assign mux_a_sel = mux_a_q;
  assign mux_b_sel = mux_b_q;
  assign irq = irq_q;

  // ==========================================================
  // Checks
  logic [15:0] since_acc_q, sh_len_q, fs_q, ra_gap_q;
  logic fsm_q, fra_q, frb_q, ra_seen_q;
  logic [4:0] half_len;
  assign half_len = 5'(ctrl3_q[C3_DIV_LSB +: 4]) + 5'h01;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      since_acc_q <= 16'h0000;
      sh_len_q <= 16'h0000;
      fs_q <= 16'h0000;
      ra_gap_q <= 16'h0000;
      fsm_q <= 1'b0;
      fra_q <= 1'b0;
      frb_q <= 1'b0;
      ra_seen_q <= 1'b0;
    end else begin
      since_acc_q <= accept ? 16'h0001 : since_acc_q + 16'h0001;
      sh_len_q <= sh_q ? sh_len_q + 16'h0001 : 16'h0000;
      fs_q <= (cap && fsm_q) ? 16'h0001 : fs_q + 16'h0001;
      ra_gap_q <= upd_a ? 16'h0001 : ra_gap_q + 16'h0001;
      fsm_q <= accept | (fsm_q & ~cap);
      fra_q <= accept | (fra_q & ~upd_a);
      frb_q <= accept | (frb_q & ~upd_b);
      ra_seen_q <= !accept && (ra_seen_q || upd_a);
    end
  end

  property p_pwr_off;
    @(posedge aclk) disable iff (!aresetn)
    (wr_do && awaddr_q == OFF_CTRL3 && wstrb_q[0] && wdata_q[7:5] == 3'h0)
      |=> ctrl3_q[7:5] == 3'h0 ##1 (st_q == ST_IDLE && !sh_q);
  endproperty
  a_pwr_off: assert property (p_pwr_off) else $error("power down write not obeyed");

  property p_mode_b;
    @(posedge aclk) disable iff (!aresetn) upd_b |-> sim_q;
  endproperty
  a_mode_b: assert property (p_mode_b) else $error("B result in sequential mode");

  property p_ext_start;
    @(posedge aclk) disable iff (!aresetn)
    (core_on && ctrl1_q[C1_EXT_EN_BIT] && external_conversion_start && !ext_prev_q)
      |=> (st_q == ST_DELAY && hcnt_q == 5'h00);
  endproperty
  a_ext_start: assert property (p_ext_start) else $error("external start ignored");

  property p_strobe_fall;
    @(posedge aclk) disable iff (!aresetn) sample_strobe |-> $fell(sample_hold);
  endproperty
  a_strobe_fall: assert property (p_strobe_fall) else $error("sample not at hold fall");

  property p_sh_width;
    @(posedge aclk) disable iff (!aresetn)
    sample_strobe |-> sh_len_q == 2 * (acq_q + 1) * half_len;
  endproperty
  a_sh_width: assert property (p_sh_width) else $error("hold pulse width wrong");

  property p_trig_delay;
    @(posedge aclk) disable iff (!aresetn)
    ($rose(sh_q) && $past(st_q) == ST_DELAY) |-> since_acc_q == DELAY_HALVES * half_len + 1;
  endproperty
  a_trig_delay: assert property (p_trig_delay) else $error("trigger to sample delay");

  property p_first_a;
    @(posedge aclk) disable iff (!aresetn)
    (upd_a && fra_q) |-> fs_q == 2 * RES_A_LAT * half_len;
  endproperty
  a_first_a: assert property (p_first_a) else $error("first A result latency");

  property p_next_seq;
    @(posedge aclk) disable iff (!aresetn)
    (upd_a && ra_seen_q && !sim_q) |-> ra_gap_q == 2 * (2 + acq_q) * half_len;
  endproperty
  a_next_seq: assert property (p_next_seq) else $error("sequential result spacing");

  property p_irq_lag;
    @(posedge aclk) disable iff (!aresetn)
    (upd_a && !sts_q[ST_A_BIT]) |-> ##1 !sts_q[ST_A_BIT] ##2 sts_q[ST_A_BIT];
  endproperty
  a_irq_lag: assert property (p_irq_lag) else $error("A flag timing wrong");

  property p_pair;
    @(posedge aclk) disable iff (!aresetn)
    (sample_strobe && sim_q) |-> (!mux_a_sel[3] && mux_b_sel == {1'b1, mux_a_sel[2:0]});
  endproperty
  a_pair: assert property (p_pair) else $error("channel pair mismatch");

  property p_first_b;
    @(posedge aclk) disable iff (!aresetn)
    (upd_b && frb_q) |-> fs_q == 2 * RES_B_LAT * half_len;
  endproperty
  a_first_b: assert property (p_first_b) else $error("first B result latency");

  property p_restart;
    @(posedge aclk) disable iff (!aresetn)
    accept |=> (div_cnt_q == 4'h0 && !hph_q && !sh_q && !pv_q[0]);
  endproperty
  a_restart: assert property (p_restart) else $error("trigger did not restart");

  property p_cov_seq;
    @(posedge aclk) disable iff (!aresetn) upd_a && !sim_q && ra_seen_q;
  endproperty
  c_cov_seq: cover property (p_cov_seq);

  property p_cov_sim;
    @(posedge aclk) disable iff (!aresetn) upd_b && !frb_q;
  endproperty
  c_cov_sim: cover property (p_cov_sim);

  property p_cov_irq;
    @(posedge aclk) disable iff (!aresetn) $rose(irq_q);
  endproperty
  c_cov_irq: cover property (p_cov_irq);
endmodule : aseq_top

// ===== aseq_pkg.sv
/*
  Shared constants for the converter sampling sequencer: register map,
  field positions, reset values, timing counts and the sequencer states.
  Assumes a 40 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
package aseq_pkg;
  // ==========================================================
  // Bus and register map
  localparam int AW = 8;
  localparam logic [7:0] OFF_CTRL1 = 8'h00;
  localparam logic [7:0] OFF_CTRL3 = 8'h04;
  localparam logic [7:0] OFF_SWTRIG = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_MASK = 8'h10;
  localparam logic [7:0] OFF_RES_A = 8'h14;
  localparam logic [7:0] OFF_RES_B = 8'h18;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  // ==========================================================
  // Fields of converter_control_reg_one
  localparam int C1_CHAN_LSB = 0;
  localparam int C1_MODE_BIT = 4;
  localparam int C1_CONT_BIT = 5;
  localparam int C1_EXT_EN_BIT = 6;
  localparam int C1_EV_EN_BIT = 7;
  localparam int C1_ACQ_LSB = 8;
  localparam logic [31:0] C1_RST = 32'h0000_0000;
  localparam logic [31:0] C1_WMASK = 32'h0000_0FFF;

  // ==========================================================
  // Fields of analog_power_control_reg
  localparam int C3_DIV_LSB = 0;
  localparam int C3_REF_BIT = 5;
  localparam int C3_BG_BIT = 6;
  localparam int C3_CORE_BIT = 7;
  localparam logic [31:0] C3_RST = 32'h0000_0000;
  localparam logic [31:0] C3_WMASK = 32'h0000_00EF;

  // ==========================================================
  // Status, mask and software trigger
  localparam int ST_A_BIT = 0;
  localparam int ST_B_BIT = 1;
  localparam int ST_BUSY_BIT = 8;
  localparam int SW_GO_BIT = 0;
  localparam logic [1:0] MASK_RST = 2'h0;

  // ==========================================================
  // Timing, in converter clocks unless noted; IRQ_LAG counts system clocks
  localparam int DELAY_HALVES = 5;
  localparam int SEQ_GAP_CLKS = 1;
  localparam int SIM_GAP_CLKS = 2;
  localparam int RES_A_LAT = 4;
  localparam int RES_B_LAT = 5;
  localparam int IRQ_LAG = 2;
  localparam int PIPE_N = RES_B_LAT;

  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_HOLD, ST_GAP} aseq_state_t;
endpackage : aseq_pkg

// ===== aseq_afe.sv
/*
  Analog front end model: quantised value of the selected A and B channels.
  Assumes the sequencer captures on the edge that ends the hold pulse.
*/
`timescale 1ns/1ps
module aseq_afe (
  input wire logic sample_hold,
  input wire logic [3:0] mux_a_sel,
  input wire logic [3:0] mux_b_sel,
  output logic [11:0] conv_in_a,
  output logic [11:0] conv_in_b
);
  // ==========================================
  // Channel values
  // Outside the hold pulse the lines show the inverse, so a capture at
  // the wrong moment reads a wrong value instead of a lucky stale one
  always_comb begin
    conv_in_a = {mux_a_sel, ~mux_a_sel, mux_a_sel} ^ 12'h5A3;
    conv_in_b = {mux_b_sel, ~mux_b_sel, mux_b_sel} ^ 12'h5A3;
    if (!sample_hold) begin
      conv_in_a = ~conv_in_a;
      conv_in_b = ~conv_in_b;
    end
  end
endmodule : aseq_afe

// ===== aseq_top_tb.sv
/*
  Self-checking bench of the sampling sequencer over AXI4-Lite.
  Assumes the front end model and a 40 MHz clock.
*/
`timescale 1ns/1ps
module aseq_top_tb;
  import aseq_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [AW-1:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0] wstrb = '0, mux_a_sel, mux_b_sel;
  logic [1:0] event_manager_triggers = '0, bresp, rresp;
  logic external_conversion_start = 0, awready, wready, bvalid, arready, rvalid;
  logic sample_hold, sample_strobe, irq, sh_l = 0, ir_l = 0;
  logic [11:0] conv_in_a, conv_in_b;
  int miscompares = 0, n_compared = 0, cyc = 0, n_st = 0, t_b, t_hr, t_hf, t_st, t_sp, t_ir;

  aseq_top aseq_top_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .event_manager_triggers(event_manager_triggers),
    .external_conversion_start(external_conversion_start), .conv_in_a(conv_in_a),
    .conv_in_b(conv_in_b), .sample_hold(sample_hold), .sample_strobe(sample_strobe),
    .mux_a_sel(mux_a_sel), .mux_b_sel(mux_b_sel), .irq(irq));
  aseq_afe aseq_afe_inst (.sample_hold(sample_hold), .mux_a_sel(mux_a_sel),
    .mux_b_sel(mux_b_sel), .conv_in_a(conv_in_a), .conv_in_b(conv_in_b));

  always #12.5 aclk = ~aclk;

  // ==========================================
  // Cycle stamps of the events that timing checks measure
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    sh_l <= sample_hold;
    ir_l <= irq;
    if (bvalid) t_b <= cyc;
    if (sample_hold && !sh_l) t_hr <= cyc;
    if (!sample_hold && sh_l) t_hf <= cyc;
    if (irq && !ir_l) t_ir <= cyc;
    if (sample_strobe) begin
      t_sp <= t_st;
      t_st <= cyc;
      n_st <= n_st + 1;
    end
  end

  // ==========================================
  // Compare, bus and closing tasks
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", w, e, g);
    end
  endtask : chk

  task automatic chk_t(input string w, input int e, input int g);
    n_compared++;
    if (g != e) begin
      miscompares++;
      $display("[FAIL] %s expected %0d seen %0d", w, e, g);
    end
  endtask : chk_t

  function automatic logic [11:0] cval(input logic [3:0] c);
    return {c, ~c, c} ^ 12'h5A3;
  endfunction : cval

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OK);
    bit a_d, w_d;
    a_d = 0;
    w_d = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!(a_d && w_d)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        a_d = 1;
        awvalid <= 0;
      end
      if (wvalid && wready) begin
        w_d = 1;
        wvalid <= 0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    chk("bresp", er, bresp);
    bready <= 0;
    @(posedge aclk);
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string w,
                      input logic [1:0] er = RESP_OK);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    chk(w, e, rdata);
    chk("rresp", er, rresp);
    rready <= 0;
    @(posedge aclk);
  endtask : rchk

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop

  // ==========================================
  // Scenarios
  task automatic s_regs();
    rchk(OFF_CTRL1, C1_RST, "ctrl1 reset");
    rchk(OFF_CTRL3, C3_RST, "ctrl3 reset");
    rchk(OFF_MASK, 0, "mask reset");
    rchk(8'h40, 0, "unmapped read", RESP_ERR);
    wr(8'h40, 32'hFFFF_FFFF, RESP_ERR);
    wr(OFF_CTRL1, 32'hFFFF_FFFF);
    rchk(OFF_CTRL1, C1_WMASK, "ctrl1 fields");
    wr(OFF_CTRL1, 0);
  endtask : s_regs

  task automatic s_core_off();
    int n0;
    n0 = n_st;
    wr(OFF_CTRL3, 32'h60);
    rchk(OFF_CTRL3, 32'h60, "bandgap and reference");
    wr(OFF_SWTRIG, 1);
    repeat (60) @(posedge aclk);
    chk_t("strobes with core off", n0, n_st);
  endtask : s_core_off

  task automatic s_seq(input int div, input int acq, input int chan);
    int h;
    h = div + 1;
    wr(OFF_CTRL3, 32'hE0 | div);
    // Core settling time: 20 us at the 25 ns clock
    repeat (800) @(posedge aclk);
    wr(OFF_MASK, 1);
    wr(OFF_CTRL1, (acq << 8) | chan);
    wr(OFF_STATUS, 3);
    wr(OFF_SWTRIG, 1);
    wait (irq === 1'b1);
    repeat (2) @(posedge aclk);
    chk_t("trigger to hold", 5 * h + 1, t_hr - t_b);
    chk_t("hold width", 2 * (1 + acq) * h, t_hf - t_hr);
    chk_t("strobe to irq", 8 * h + 3, t_ir - t_st);
    rchk(OFF_RES_A, cval(4'(chan)), "result a");
    rchk(OFF_STATUS, 1, "status");
    wr(OFF_STATUS, 1);
    @(posedge aclk);
    chk("irq cleared", 0, irq);
  endtask : s_seq

  task automatic s_cont(input int sim, input int acq, input int div, input int chan,
                        input int src);
    int n0;
    n0 = n_st;
    wr(OFF_CTRL3, 32'hE0 | div);
    repeat (800) @(posedge aclk);
    wr(OFF_MASK, 0);
    wr(OFF_STATUS, 3);
    wr(OFF_CTRL1, (acq << 8) | 32'hE0 | (sim << 4) | chan);
    {event_manager_triggers, external_conversion_start} <= src ? 3'h4 : 3'h1;
    repeat (3) @(posedge aclk);
    {event_manager_triggers, external_conversion_start} <= 3'h0;
    wait (n_st >= n0 + 3);
    @(posedge aclk);
    chk_t("strobe period", 2 * (2 + sim + acq) * (div + 1), t_st - t_sp);
    chk("mux a", chan, mux_a_sel);
    if (sim) chk("mux b", chan + 8, mux_b_sel);
    wr(OFF_CTRL3, 0);
    n0 = n_st;
    repeat (40) @(posedge aclk);
    chk_t("strobes after power down", n0, n_st);
    chk("hold after power down", 0, sample_hold);
    rchk(OFF_RES_A, cval(4'(chan)), "result a");
    if (sim) rchk(OFF_RES_B, cval(4'(chan + 8)), "result b");
    rchk(OFF_STATUS, sim ? 3 : 1, "status flags");
    chk("irq masked", 0, irq);
  endtask : s_cont

  // ==========================================
  // Main sequence and watchdog
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    s_regs();
    s_core_off();
    s_seq(0, 0, 5);
    s_seq(1, 15, 10);
    s_cont(0, 2, 1, 12, 0);
    s_cont(1, 1, 0, 3, 1);
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    report_and_stop();
  end
endmodule : aseq_top_tb
